// ### design/adcpms_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: host waits 1 ms after supplies up
// R2: after init, device enters low-power sleep
// R3: clearing sleep starts 1 ms wake sequence
// R4: host enables inputs, slots, then power
// R5: host may start clocks after wake write
// R6: host selects PDM source before enabling
// R7: host sets PDM clock and data pins
// R8: PDM input one feeds ch1/2, two ch3/4
// R9: sleep request ramps volume, powers down
// R10: status bit shows sleep reached
// R11: configuration kept through sleep
// R12: re-wake, wait, restart clocks
// R13: host repeats sleep/wake or full config
// R14: host waits 2 ms, stable supplies
// R15: supply power-down allows 10 ms
// R16: supply loss without interval: abrupt shutdown
// R17: 100 ms between power-down and power-up
// R18: slow ramp: software reset first
// R19: regulator select defaults zero, set on wake
// R20: host holds digital inputs steady
// R21: TDM slave output on host clocks
// R22: host writes nothing during waits
module adcpms_top
    import adcpms_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC
)(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        SUPPLY_OK,
    input  wire logic        SOFT_RESET,
    input  wire logic        SLEEP_REQ,
    input  wire logic        REG_SELECT_REQ,
    input  wire logic        CFG_WRITE,
    input  wire adcpms_cfg_t CFG_IN,
    input  wire logic        FRAME_SYNC,
    input  wire logic        BIT_CLK,
    input  wire logic [1:0]  PDM_DATA_IN,
    output logic             SLEEP_REACHED,
    output logic             ACTIVE,
    output logic             WAKE_BUSY,
    output logic             REGULATOR_ON,
    output logic             ABRUPT_OFF,
    output logic [7:0]       VOLUME,
    output logic             PDM_CLOCK_OUT,
    output logic             SERIAL_DATA_OUT
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    logic [1:0] clk_prev_ff;
    wire  [4:0] pins = {SUPPLY_OK, FRAME_SYNC, BIT_CLK, PDM_DATA_IN};

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pin_s1_ff   <= '0;
            pin_s2_ff   <= '0;
            clk_prev_ff <= '0;
        end else begin
            pin_s1_ff   <= pins;
            pin_s2_ff   <= pin_s1_ff;
            clk_prev_ff <= pin_s2_ff[3:2];
        end
    end

    wire supply_ok  = pin_s2_ff[4];
    wire frame_sync_rise = pin_s2_ff[3] & ~clk_prev_ff[1];
    wire bclk_fall  = ~pin_s2_ff[2] & clk_prev_ff[0];
    wire [1:0] pdm_din = pin_s2_ff[1:0];

    // ****************************************
    // power mode sequencer
    // ****************************************
    adcpms_state_t    state_ff;
    adcpms_state_t    nxt_state;
    logic [TMR_W-1:0] timer_ff;
    logic [TMR_W-1:0] nxt_timer;
    logic [7:0]       volume_ff;
    logic [7:0]       nxt_volume;
    logic [7:0]       step_ff;
    logic             reg_sel_ff;
    logic             abrupt_ff;
    adcpms_cfg_t      cfg_ff;

    wire timer_done = (timer_ff == '0);
    wire step_tick  = (step_ff == 8'(RAMP_STEP_CYC - 1));
    wire running    = (state_ff == ST_ACTIVE) || (state_ff == ST_RAMP);

    always_comb begin
        nxt_state  = state_ff;
        nxt_timer  = timer_done ? timer_ff : timer_ff - 1'b1;
        nxt_volume = volume_ff;
        case (state_ff)
            ST_OFF: begin
                if (supply_ok) begin
                    nxt_state = ST_INIT;
                    nxt_timer = TMR_W'(INIT_CYCLES - 1);
                end
            end
            ST_INIT: begin
                if (timer_done) begin
                    nxt_state = ST_SLEEP;                           // R2
                end
            end
            ST_SLEEP: begin
                if (!SLEEP_REQ) begin
                    nxt_state = ST_WAKE;                            // R3
                    nxt_timer = TMR_W'(WAKE_CYCLES - 1);
                end
            end
            ST_WAKE: begin
                if (timer_done) begin
                    nxt_state  = ST_ACTIVE;
                    nxt_volume = VOL_FULL;
                end
            end
            ST_ACTIVE: begin
                if (SLEEP_REQ) begin
                    nxt_state = ST_RAMP;                            // R9
                end
            end
            ST_RAMP: begin
                // ramp is time based so it ends even if the frame clock is gone
                if (volume_ff == VOL_ZERO) begin
                    nxt_state = ST_SLEEP;                           // R9
                end else if (step_tick) begin
                    nxt_volume = volume_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
        if (state_ff == ST_WAKE && SLEEP_REQ && !timer_done) begin
            nxt_state = ST_SLEEP;
        end
        if (!supply_ok) begin
            nxt_state  = ST_OFF;                                    // R16
            nxt_volume = VOL_ZERO;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || SOFT_RESET) begin
            state_ff <= ST_OFF;
            timer_ff <= '0;
            volume_ff <= VOL_ZERO;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            volume_ff <= nxt_volume;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || state_ff != ST_RAMP || step_tick) begin
            step_ff <= '0;
        end else begin
            step_ff <= step_ff + 1'b1;
        end
    end

    // ****************************************
    // configuration, regulator, flags
    // ****************************************
    always_ff @(posedge CLK) begin
        if (RESET || SOFT_RESET) begin
            cfg_ff     <= CFG_RST;                                  // R18
            reg_sel_ff <= REG_SEL_RST;                              // R19
            abrupt_ff  <= 1'b0;
        end else begin
            if (CFG_WRITE && state_ff != ST_OFF && state_ff != ST_INIT) begin
                cfg_ff <= CFG_IN;                                   // R11
            end
            if (state_ff == ST_SLEEP && !SLEEP_REQ) begin
                reg_sel_ff <= REG_SELECT_REQ;                       // R19
            end
            if (state_ff == ST_OFF) begin
                reg_sel_ff <= REG_SEL_RST;
            end
            if (!supply_ok && state_ff != ST_OFF) begin
                abrupt_ff <= running;                               // R16
            end else if (state_ff == ST_INIT) begin
                abrupt_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // PDM capture
    // ****************************************
    logic [2:0]       pdm_div_ff;
    logic             pdm_clk_ff;
    logic [SMP_W-1:0] acc_ff [4];
    adcpms_frame_t    frame_ff;

    wire pdm_on   = running && cfg_ff.pdm_mode && cfg_ff.adc_pwr;
    wire pdm_edge = pdm_on && (pdm_div_ff == 3'(PDM_HALF_CYC - 1));

    function automatic logic [SMP_W-1:0] scale(input logic [SMP_W-1:0] a, input logic [7:0] v);
        logic [SMP_W+7:0] p;
        p = a * v;
        return p[SMP_W+7:8];
    endfunction : scale

    always_ff @(posedge CLK) begin
        if (RESET || !pdm_on || pdm_edge) begin
            pdm_div_ff <= '0;
        end else begin
            pdm_div_ff <= pdm_div_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || !pdm_on) begin
            pdm_clk_ff <= 1'b0;
        end else if (pdm_edge) begin
            pdm_clk_ff <= ~pdm_clk_ff;
        end
    end

    // odd channels sampled at end of high phase, even at end of low phase
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < 4; i++) begin
                acc_ff[i] <= '0;
            end
            frame_ff <= '0;
        end else if (frame_sync_rise) begin
            frame_ff.ch1 <= scale(acc_ff[0], volume_ff);
            frame_ff.ch2 <= scale(acc_ff[1], volume_ff);
            frame_ff.ch3 <= scale(acc_ff[2], volume_ff);
            frame_ff.ch4 <= scale(acc_ff[3], volume_ff);
            for (int i = 0; i < 4; i++) begin
                acc_ff[i] <= '0;
            end
        end else if (pdm_edge) begin
            for (int i = 0; i < 4; i++) begin
                if (cfg_ff.in_ch_en[3-i] && (pdm_clk_ff == ((i % 2) == 0)) && pdm_din[i/2]) begin
                    acc_ff[i] <= acc_ff[i] + 1'b1;                  // R8
                end
            end
        end
    end

    // ****************************************
    // serial output and status
    // ****************************************
    logic sd;
    wire  tx_load = frame_sync_rise && running;

    adcpms_tdm_tx #(
        .W       (SMP_W)
    ) u_tx (
        .clk     (CLK),
        .rst     (RESET),
        .load    (tx_load),                                         // R21
        .shift   (bclk_fall && running),
        .slot_en (cfg_ff.slot_en),
        .frame   (frame_ff),
        .sd      (sd)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            SLEEP_REACHED   <= 1'b0;
            ACTIVE          <= 1'b0;
            WAKE_BUSY       <= 1'b0;
            REGULATOR_ON    <= 1'b0;
            ABRUPT_OFF      <= 1'b0;
            VOLUME          <= VOL_ZERO;
            PDM_CLOCK_OUT   <= 1'b0;
            SERIAL_DATA_OUT <= 1'b0;
        end else begin
            SLEEP_REACHED   <= (state_ff == ST_SLEEP);              // R10
            ACTIVE          <= (state_ff == ST_ACTIVE);
            WAKE_BUSY       <= (state_ff == ST_WAKE) || (state_ff == ST_INIT);
            REGULATOR_ON    <= reg_sel_ff && state_ff != ST_OFF;
            ABRUPT_OFF      <= abrupt_ff;
            VOLUME          <= volume_ff;
            PDM_CLOCK_OUT   <= pdm_clk_ff;
            SERIAL_DATA_OUT <= sd & running;
        end
    end

endmodule : adcpms_top

// ### design/adcpms_pkg.sv
package adcpms_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int INIT_TIME_US    = 1000;
    localparam int WAKE_TIME_US    = 1000;
    localparam int RAMP_STEP_NS    = 20000;
    localparam int CLK_PER_MHZ     = CLK_HZ / 1_000_000;
    localparam int INIT_CYC        = INIT_TIME_US * CLK_PER_MHZ;
    localparam int WAKE_CYC        = WAKE_TIME_US * CLK_PER_MHZ;
    localparam int RAMP_STEP_CYC   = (RAMP_STEP_NS * (CLK_HZ / 1000) + 999_999) / 1_000_000;
    localparam int PDM_HALF_CYC    = 4;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int          SMP_W       = 16;
    localparam int          TMR_W       = 16;
    localparam logic [7:0]  VOL_FULL    = 8'hFF;
    localparam logic [7:0]  VOL_ZERO    = 8'h00;
    localparam logic        REG_SEL_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_INIT,
        ST_SLEEP,
        ST_WAKE,
        ST_ACTIVE,
        ST_RAMP
    } adcpms_state_t;

    typedef struct packed {
        logic [3:0] in_ch_en;
        logic [3:0] slot_en;
        logic       adc_pwr;
        logic       pdm_mode;
    } adcpms_cfg_t;

    localparam adcpms_cfg_t CFG_RST = '0;

    // ch1 sits in the top bits so it leaves the serial port first
    typedef struct packed {
        logic [SMP_W-1:0] ch1;
        logic [SMP_W-1:0] ch2;
        logic [SMP_W-1:0] ch3;
        logic [SMP_W-1:0] ch4;
    } adcpms_frame_t;

endpackage : adcpms_pkg

// ### design/adcpms_tdm_tx.sv
`timescale 1ns/1ps
module adcpms_tdm_tx
    import adcpms_pkg::*;
#(
    parameter int W = SMP_W
)(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           load,
    input  wire logic           shift,
    input  wire logic [3:0]     slot_en,
    input  wire adcpms_frame_t  frame,
    output logic                sd
);

    logic [4*W-1:0] shreg_ff;
    logic [4*W-1:0] masked;

    always_comb begin
        masked = frame;
        for (int i = 0; i < 4; i++) begin
            if (!slot_en[3-i]) begin
                masked[(3-i)*W +: W] = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shreg_ff <= '0;
            sd       <= 1'b0;
        end else if (load) begin
            sd       <= masked[4*W-1];
            shreg_ff <= {masked[4*W-2:0], 1'b0};
        end else if (shift) begin
            sd       <= shreg_ff[4*W-1];
            shreg_ff <= {shreg_ff[4*W-2:0], 1'b0};
        end
    end

endmodule : adcpms_tdm_tx

// ### tb/adcpms_checker.sv
`timescale 1ns/1ps
module adcpms_checker
    import adcpms_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
)(
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic       SUPPLY_OK,
    input wire logic       SLEEP_REACHED,
    input wire logic       ACTIVE,
    input wire logic       WAKE_BUSY,
    input wire logic       REGULATOR_ON,
    input wire logic       ABRUPT_OFF,
    input wire logic [7:0] VOLUME,
    input wire logic       PDM_CLOCK_OUT
);
    // ****
    // busy run length, read when active rises
    // ****
    logic [15:0] busy_ff;
    wire  [15:0] nxt_busy = WAKE_BUSY ? busy_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge CLK) begin
        busy_ff <= RESET ? 16'h0000 : nxt_busy;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_hi4;
        (PDM_CLOCK_OUT || !ACTIVE) [*4];
    endsequence
    property p_wake_len;
        $rose(ACTIVE) |-> busy_ff >= WAKE_CYCLES - 2 && busy_ff <= WAKE_CYCLES + 2;
    endproperty
    property p_vol_full;
        $rose(ACTIVE) |-> VOLUME == VOL_FULL;
    endproperty
    // supply must have been steady, a loss drops volume to zero at once
    property p_ramp;
        SUPPLY_OK && $past(SUPPLY_OK, 4) && VOLUME < $past(VOLUME) |-> VOLUME == $past(VOLUME) - 8'h01;
    endproperty
    property p_sleep_zero;
        $rose(SLEEP_REACHED) |-> VOLUME == VOL_ZERO;
    endproperty
    property p_excl;
        !(SLEEP_REACHED && ACTIVE);
    endproperty
    property p_reg_hold;
        ACTIVE && $past(ACTIVE) |-> $stable(REGULATOR_ON);
    endproperty
    property p_abrupt;
        $rose(ABRUPT_OFF) |-> !$past(SUPPLY_OK, 2);
    endproperty
    property p_pdm_half;
        $rose(PDM_CLOCK_OUT) |-> s_hi4 ##1 !PDM_CLOCK_OUT;
    endproperty
    // the pdm clock keeps running through the volume ramp, when active is already low
    property p_pdm_act;
        PDM_CLOCK_OUT |-> ACTIVE || $past(ACTIVE) || $past(VOLUME, 2) != VOL_ZERO;
    endproperty
    a_wake_len:   assert property (p_wake_len)   else $error("wake time wrong");
    a_vol_full:   assert property (p_vol_full)   else $error("volume not full");
    a_ramp:       assert property (p_ramp)       else $error("ramp step wrong");
    a_sleep_zero: assert property (p_sleep_zero) else $error("sleep at volume");
    a_excl:       assert property (p_excl)       else $error("sleep and active");
    a_reg_hold:   assert property (p_reg_hold)   else $error("regulator moved");
    a_abrupt:     assert property (p_abrupt)     else $error("abrupt no loss");
    a_pdm_half:   assert property (p_pdm_half)   else $error("pdm half period");
    a_pdm_act:    assert property (p_pdm_act)    else $error("pdm clock idle");
endmodule : adcpms_checker

bind adcpms_top adcpms_checker #(.WAKE_CYCLES(WAKE_CYCLES)) adcpms_checker_i (.CLK, .RESET, .SUPPLY_OK,
    .SLEEP_REACHED, .ACTIVE, .WAKE_BUSY, .REGULATOR_ON, .ABRUPT_OFF, .VOLUME, .PDM_CLOCK_OUT);

// ### tb/adcpms_host_model.sv
`timescale 1ns/1ps
module adcpms_host_model
    import adcpms_pkg::*;
(
    input  wire logic    run,
    input  wire logic    pdm_clk,
    input  wire logic    sd,
    output logic         frame_sync,
    output logic         bclk,
    output logic [1:0]   pdm,
    output adcpms_frame_t rx,
    output int           n_frames
);
    // pin 0 high only in clock-high phase, pin 1 only in low phase
    assign pdm = {~pdm_clk, pdm_clk};
    // bit clock stands still between frames; sample just before each fall
    initial begin
        frame_sync = 1'b0;
        bclk = 1'b0;
        rx = '0;
        n_frames = 0;
        forever begin
            wait (run);
            // keep every frame sync and bit clock edge clear of the device's sampling edge
            #20 frame_sync = 1'b1;
            for (int i = 63; i >= 0; i--) begin
                #400 bclk = 1'b1;
                frame_sync = 1'b0;
                #350 rx[i] = sd;
                #50 bclk = 1'b0;
            end
            n_frames++;
            #1980;
        end
    end
endmodule : adcpms_host_model

// ### tb/adcpms_top_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module adcpms_top_test
    import adcpms_pkg::*;
;
    localparam int N = 50;
    logic          CLK = 1'b0;
    logic          RESET = 1'b1;
    logic          SUPPLY_OK = 1'b0;
    logic          SOFT_RESET = 1'b0;
    logic          SLEEP_REQ = 1'b1;
    logic          REG_SELECT_REQ = 1'b0;
    logic          CFG_WRITE = 1'b0;
    adcpms_cfg_t   CFG_IN = CFG_RST;
    logic          run = 1'b0;
    logic          FRAME_SYNC, BIT_CLK, SLEEP_REACHED, ACTIVE, WAKE_BUSY;
    logic          REGULATOR_ON, ABRUPT_OFF, PDM_CLOCK_OUT, SERIAL_DATA_OUT;
    logic [1:0]    PDM_DATA_IN;
    logic [7:0]    VOLUME;
    adcpms_frame_t rx;
    int            n_frames;
    int            n_errors = 0;
    int            n_checks = 0;
    int            cyc = 0;
    adcpms_top #(.INIT_CYCLES(N), .WAKE_CYCLES(N)) adcpms_top_i (.CLK, .RESET, .SUPPLY_OK, .SOFT_RESET,
        .SLEEP_REQ, .REG_SELECT_REQ, .CFG_WRITE, .CFG_IN, .FRAME_SYNC, .BIT_CLK, .PDM_DATA_IN,
        .SLEEP_REACHED, .ACTIVE, .WAKE_BUSY, .REGULATOR_ON, .ABRUPT_OFF, .VOLUME, .PDM_CLOCK_OUT,
        .SERIAL_DATA_OUT);
    adcpms_host_model adcpms_host_model_i (.run, .pdm_clk(PDM_CLOCK_OUT), .sd(SERIAL_DATA_OUT),
        .frame_sync(FRAME_SYNC), .bclk(BIT_CLK), .pdm(PDM_DATA_IN), .rx, .n_frames);
    always #50 CLK = ~CLK;
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic tick;
        @(posedge CLK);
        #1;
    endtask : tick
    task automatic wr(input adcpms_cfg_t c);
        @(posedge CLK) begin
            CFG_IN    <= c;
            CFG_WRITE <= 1'b1;
        end
        @(posedge CLK) CFG_WRITE <= 1'b0;
    endtask : wr
    task automatic frames(input int n);
        int f;
        f = n_frames;
        for (int i = 0; i < 5000 && n_frames < f + n; i++) tick;
        `CHK(n_frames >= f + n, 1'b1)
    endtask : frames
    task automatic t_init;
        int i;
        repeat (8) @(posedge CLK);
        RESET <= 1'b0;
        tick;
        `CHK({SLEEP_REACHED, ACTIVE, REGULATOR_ON, VOLUME}, 11'h000)
        @(posedge CLK) SUPPLY_OK <= 1'b1;
        for (i = 0; i < 300 && SLEEP_REACHED !== 1'b1; i++) tick;
        `CHK(i >= N && i <= N + 8, 1'b1)
    endtask : t_init
    task automatic t_wake(input logic sel);
        int i;
        @(posedge CLK) begin
            SLEEP_REQ      <= 1'b0;
            REG_SELECT_REQ <= sel;
        end
        repeat (3) tick;
        `CHK({WAKE_BUSY, SLEEP_REACHED}, 2'b10)
        for (i = 0; i < 300 && ACTIVE !== 1'b1; i++) tick;
        `CHK(i >= N - 4 && i <= N + 2, 1'b1)
        `CHK(VOLUME, VOL_FULL)
        `CHK(REGULATOR_ON, sel)
    endtask : t_wake
    task automatic t_cfg;
        adcpms_cfg_t st [3];
        int          n;
        logic        p;
        st = '{'{4'hF, 4'h0, 1'b0, 1'b1}, '{4'hF, 4'hF, 1'b0, 1'b1}, '{4'hF, 4'hF, 1'b1, 1'b1}};
        @(posedge CLK) run <= 1'b1;
        foreach (st[k]) wr(st[k]);
        n = 0;
        p = 1'b1;
        repeat (40) begin
            tick;
            if (PDM_CLOCK_OUT === 1'b1 && p === 1'b0) n++;
            p = PDM_CLOCK_OUT;
        end
        `CHK(n, 5)
        frames(3);
        `CHK({rx.ch1 != 16'h0000, rx.ch2, rx.ch3, rx.ch4 != 16'h0000}, 34'h200000001)
        wr('{4'hF, 4'h7, 1'b1, 1'b1});
        frames(2);
        `CHK({rx.ch1, rx.ch4 != 16'h0000}, 17'h00001)
    endtask : t_cfg
    task automatic t_sleep;
        int i;
        @(posedge CLK) SLEEP_REQ <= 1'b1;
        for (i = 0; i < 60000 && SLEEP_REACHED !== 1'b1; i++) tick;
        `CHK(i >= 254 * RAMP_STEP_CYC && i <= 256 * RAMP_STEP_CYC, 1'b1)
        `CHK({VOLUME, ACTIVE, ABRUPT_OFF}, 10'h000)
        @(posedge CLK) run <= 1'b0;
        repeat (600) tick;
        t_wake(1'b0);
        @(posedge CLK) run <= 1'b1;
        frames(3);
        `CHK({rx.ch1, rx.ch4 != 16'h0000}, 17'h00001)
    endtask : t_sleep
    task automatic t_power;
        int i;
        @(posedge CLK) SUPPLY_OK <= 1'b0;
        repeat (6) tick;
        `CHK({ABRUPT_OFF, ACTIVE, VOLUME}, 10'h200)
        @(posedge CLK) run <= 1'b0;
        repeat (100) tick;
        @(posedge CLK) SUPPLY_OK <= 1'b1;
        @(posedge CLK) SOFT_RESET <= 1'b1;
        @(posedge CLK) SOFT_RESET <= 1'b0;
        for (i = 0; i < 300 && SLEEP_REACHED !== 1'b1; i++) tick;
        `CHK({ABRUPT_OFF, REGULATOR_ON}, 2'b00)
        @(posedge CLK) SUPPLY_OK <= 1'b0;
        repeat (6) tick;
        `CHK(ABRUPT_OFF, 1'b0)
    endtask : t_power
    initial begin
        t_init;
        t_wake(1'b1);
        t_cfg;
        t_sleep;
        t_power;
        summarize();
    end
endmodule : adcpms_top_test
